/* File: emulated_eeprom_defs.svh */
// offsets, field positions, command codes and counts of the emulated eeprom controller
`ifndef EMULATED_EEPROM_DEFS_SVH
`define EMULATED_EEPROM_DEFS_SVH
`define EE_ROWS         1024
`define EE_ADDR_W       11
`define EE_REG_BLOCK    10'h004
`define EE_REG_LAST     4'hb
`define EE_REG_CLKDIV   4'h0
`define EE_REG_RSVD_A   4'h1
`define EE_REG_RSVD_B   4'h2
`define EE_REG_CFG      4'h3
`define EE_REG_PROT     4'h4
`define EE_REG_STAT     4'h5
`define EE_REG_CMD      4'h6
`define EE_REG_RSVD_C   4'h7
`define EE_REG_ADDRHI   4'h8
`define EE_REG_ADDRLO   4'h9
`define EE_REG_DATAHI   4'ha
`define EE_REG_DATALO   4'hb
`define EE_DIV_LOADED   7
`define EE_DIV_PRE8     6
`define EE_CFG_CMD_BUFFER_EMPTY_IRQ_EN    7
`define EE_CFG_CCIE     6
`define EE_PR_OPEN      7
`define EE_PR_DIS       3
`define EE_ST_CMD_BUFFER_EMPTY_FLAG     7
`define EE_ST_PVIOL     5
`define EE_ST_ACCERR    4
`define EE_CMD_VERIFY   7'h05
`define EE_CMD_PROG     7'h20
`define EE_CMD_SERASE   7'h40
`define EE_CMD_MERASE   7'h41
`define EE_ARRAY_END    12'h800
`define EE_FIELD_LO     11'h7f0
`define EE_PROT_BYTE    11'h7fd
`define EE_ERASED       16'hffff
`define EE_BUSY_DATA    16'h0000
`define EE_PROG_TICKS   16'h0006
`define EE_SERASE_TICKS 16'h0014
`define EE_MERASE_TICKS 16'h0028
`endif

/* File: emulated_eeprom_pkg.sv */
// types of the emulated eeprom controller
package emulated_eeprom_pkg;
	typedef enum logic [2:0] {E_IDLE = 3'b001, E_WAIT = 3'b010, E_WALK = 3'b100} eng_state_type;
	typedef enum logic [2:0] {S_IDLE = 3'b001, S_DATA = 3'b010, S_CMD = 3'b100} seq_state_type;
	typedef struct packed {
		logic          load;
		logic          avs_wait;
		logic [31:0]   rdata;
		logic          mis;
		logic [7:0]    mis_byte;
		logic [7:0]    clkdiv;
		logic          cmd_buffer_empty_irq_en;
		logic          ccie;
		logic [7:0]    prot;
		logic          cmd_buffer_empty_flag;
		logic          pviol;
		logic          accerr;
		logic          blank;
		seq_state_type seq;
		logic [15:0]   addr;
		logic [15:0]   data;
		logic [6:0]    cmd;
		eng_state_type eng;
		logic [6:0]    act_cmd;
		logic [15:0]   act_data;
		logic [9:0]    row;
		logic [9:0]    end_row;
		logic          clean;
		logic [2:0]    pre;
		logic [5:0]    div;
		logic          tick;
		logic [15:0]   cnt;
		logic          irq;
	} state_type;
endpackage : emulated_eeprom_pkg

/* File: emulated_eeprom_controller.sv */
// emulated eeprom controller: array, command pipeline, protection, avalon-mm slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "emulated_eeprom_defs.svh"
module emulated_eeprom_controller #(
	parameter logic [15:0] PROG_TICKS   = `EE_PROG_TICKS,
	parameter logic [15:0] SERASE_TICKS = `EE_SERASE_TICKS,
	parameter logic [15:0] MERASE_TICKS = `EE_MERASE_TICKS,
	parameter logic [9:0]  REG_BLOCK    = `EE_REG_BLOCK
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic [15:0] i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	input  wire logic [4:0]  i_system_nvm_base_map,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_cmd_irq
);
	import emulated_eeprom_pkg::*;

	if (PROG_TICKS == 16'h0 || SERASE_TICKS == 16'h0 || MERASE_TICKS == 16'h0) begin : g_chk
		$error("tick counts must be nonzero");
	end

	localparam logic [10:0] PB = `EE_PROT_BYTE;

	state_type   st_r;
	state_type   st_nxt;
	logic [15:0] mem [0:`EE_ROWS-1];
	logic        mem_we;
	logic [9:0]  mem_row;
	logic [15:0] mem_wdata;
	logic [10:0] a;
	logic        arr_hit;
	logic        reg_hit;
	logic [3:0]  idx;
	logic        be_byte;
	logic        misaligned;
	logic        busy;
	logic        cmd_complete_flag;
	logic [15:0] w0;
	logic [15:0] w1;
	logic [15:0] wp;
	logic [7:0]  prot_byte;
	logic [7:0]  reg_rd;
	logic [7:0]  wd;
	logic        viol;

	////////////////////////////////////////////////////////////////////////////////
	// protection

	function automatic logic row_prot(input logic [7:0] p, input logic [9:0] r);
		logic [11:0] lim;
		lim = `EE_ARRAY_END - 12'({({1'b0, p[2:0]} + 4'h1), 6'h00});
		return !p[`EE_PR_OPEN] || (!p[`EE_PR_DIS] && {1'b0, r, 1'b0} >= lim);
	endfunction : row_prot

	// no reset on the array: it stands for nonvolatile cells, filled erased at start
	initial begin
		for (int i = 0; i < `EE_ROWS; i++) begin
			mem[i] = `EE_ERASED;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (mem_we) begin
			mem[mem_row] <= mem_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode

	assign a          = i_avs_address[10:0];
	assign arr_hit    = i_avs_address[15:11] == i_system_nvm_base_map;
	assign idx        = i_avs_address[5:2];
	assign reg_hit    = !arr_hit && i_avs_address[15:6] == REG_BLOCK && idx <= `EE_REG_LAST;
	assign be_byte    = i_avs_byteenable == 4'h1;
	assign misaligned = a[0] && !be_byte;
	assign busy       = st_r.eng != E_IDLE;
	assign cmd_complete_flag       = !busy && st_r.cmd_buffer_empty_flag;
	assign w0         = mem[a[10:1]];
	assign w1         = mem[a[10:1] + 10'h1];
	assign wp         = mem[PB[10:1]];
	assign prot_byte  = PB[0] ? wp[7:0] : wp[15:8];
	assign wd         = i_avs_writedata[7:0];

	always_comb begin
		unique case (st_r.cmd)
			`EE_CMD_PROG,
			`EE_CMD_SERASE: viol = row_prot(st_r.prot, st_r.addr[10:1]);
			`EE_CMD_MERASE: viol = !(st_r.prot[`EE_PR_OPEN] && st_r.prot[`EE_PR_DIS]);
			default:        viol = 1'b0;
		endcase
	end

	always_comb begin
		unique case (idx)
			`EE_REG_CLKDIV: reg_rd = st_r.clkdiv;
			`EE_REG_CFG:    reg_rd = {st_r.cmd_buffer_empty_irq_en, st_r.ccie, 6'h00};
			`EE_REG_PROT:   reg_rd = st_r.prot;
			`EE_REG_STAT:   reg_rd = {st_r.cmd_buffer_empty_flag, cmd_complete_flag, st_r.pviol, st_r.accerr, 1'b0,
				st_r.blank, 2'h0};
			`EE_REG_CMD:    reg_rd = {1'b0, st_r.cmd};
			`EE_REG_ADDRHI: reg_rd = st_r.addr[15:8];
			`EE_REG_ADDRLO: reg_rd = st_r.addr[7:0];
			`EE_REG_DATAHI: reg_rd = st_r.data[15:8];
			`EE_REG_DATALO: reg_rd = st_r.data[7:0];
			default:        reg_rd = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt    = st_r;
		mem_we    = 1'b0;
		mem_row   = st_r.row;
		mem_wdata = `EE_ERASED;
		st_nxt.tick = 1'b0;
		// algorithm time base, only once the divider has been written
		if (st_r.clkdiv[`EE_DIV_LOADED]) begin
			if (st_r.clkdiv[`EE_DIV_PRE8] && st_r.pre != 3'h7) begin
				st_nxt.pre = st_r.pre + 3'h1;
			end else begin
				st_nxt.pre = 3'h0;
				if (st_r.div == st_r.clkdiv[5:0]) begin
					st_nxt.div  = 6'h00;
					st_nxt.tick = 1'b1;
				end else begin
					st_nxt.div = st_r.div + 6'h01;
				end
			end
		end
		if (st_r.load) begin
			st_nxt.prot = prot_byte;
			st_nxt.load = 1'b0;
		end else if ((i_avs_read || i_avs_write) && st_r.avs_wait) begin
			if (i_avs_read && arr_hit && misaligned && !busy && !st_r.mis) begin
				st_nxt.mis      = 1'b1;
				st_nxt.mis_byte = w0[7:0];
			end else begin
				st_nxt.avs_wait = 1'b0;
				st_nxt.mis      = 1'b0;
				st_nxt.rdata    = 32'h0;
				if (i_avs_read && arr_hit) begin
					if (busy) begin
						st_nxt.rdata[15:0] = `EE_BUSY_DATA;
					end else if (st_r.mis) begin
						st_nxt.rdata[15:0] = {st_r.mis_byte, w1[15:8]};
					end else if (be_byte) begin
						st_nxt.rdata[7:0] = a[0] ? w0[7:0] : w0[15:8];
					end else begin
						st_nxt.rdata[15:0] = w0;
					end
				end else if (i_avs_read && reg_hit) begin
					st_nxt.rdata[7:0] = reg_rd;
				end
			end
		end else if (i_avs_write && !st_r.avs_wait) begin
			// write takes effect at the accepting edge
			st_nxt.avs_wait = 1'b1;
			if (arr_hit) begin
				if (st_r.seq == S_IDLE && st_r.cmd_buffer_empty_flag && st_r.clkdiv[`EE_DIV_LOADED] &&
					!st_r.pviol && !st_r.accerr && !be_byte) begin
					st_nxt.addr = {5'h00, a};
					st_nxt.data = i_avs_writedata[15:0];
					st_nxt.seq  = S_DATA;
				end else begin
					st_nxt.accerr = 1'b1;
					st_nxt.seq    = S_IDLE;
				end
			end else if (reg_hit && i_avs_byteenable[0]) begin
				unique case (idx)
					`EE_REG_CLKDIV: begin
						if (!st_r.clkdiv[`EE_DIV_LOADED]) begin
							st_nxt.clkdiv = {1'b1, wd[6:0]};
						end
					end
					`EE_REG_CFG: begin
						st_nxt.cmd_buffer_empty_irq_en = wd[`EE_CFG_CMD_BUFFER_EMPTY_IRQ_EN];
						st_nxt.ccie  = wd[`EE_CFG_CCIE];
					end
					`EE_REG_PROT: begin
						// open and disable bits can only move to the protected side
						st_nxt.prot[`EE_PR_OPEN] = st_r.prot[`EE_PR_OPEN] & wd[`EE_PR_OPEN];
						st_nxt.prot[`EE_PR_DIS]  = st_r.prot[`EE_PR_DIS] & wd[`EE_PR_DIS];
						if (st_r.prot[`EE_PR_DIS]) begin
							st_nxt.prot[2:0] = wd[2:0];
						end
					end
					`EE_REG_STAT: begin
						if (wd[`EE_ST_PVIOL]) begin
							st_nxt.pviol = 1'b0;
						end
						if (wd[`EE_ST_ACCERR]) begin
							st_nxt.accerr = 1'b0;
						end
						if (wd[`EE_ST_CMD_BUFFER_EMPTY_FLAG] && st_r.seq == S_CMD) begin
							st_nxt.cmd_buffer_empty_flag = 1'b0;
							st_nxt.seq   = S_IDLE;
						end
					end
					`EE_REG_CMD: begin
						if (st_r.seq == S_DATA && (wd[6:0] == `EE_CMD_PROG ||
							wd[6:0] == `EE_CMD_SERASE || wd[6:0] == `EE_CMD_MERASE ||
							wd[6:0] == `EE_CMD_VERIFY)) begin
							st_nxt.cmd = wd[6:0];
							st_nxt.seq = S_CMD;
						end else begin
							st_nxt.accerr = 1'b1;
							st_nxt.seq    = S_IDLE;
						end
					end
					`EE_REG_ADDRHI: st_nxt.addr[15:8] = wd;
					`EE_REG_ADDRLO: st_nxt.addr[7:0]  = wd;
					`EE_REG_DATAHI: st_nxt.data[15:8] = wd;
					`EE_REG_DATALO: st_nxt.data[7:0]  = wd;
					default: ;
				endcase
			end
		end else if (!st_r.avs_wait) begin
			// read answer stands one cycle only, so a stale answer cannot accept the next request
			st_nxt.avs_wait = 1'b1;
		end
		// a protected target aborts the sequence one cycle after the command lands
		if (st_r.seq == S_CMD && viol) begin
			st_nxt.pviol = 1'b1;
			st_nxt.seq   = S_IDLE;
		end
		// command engine: runs the timed algorithm with no master involvement
		unique case (st_r.eng)
			E_IDLE: begin
				if (!st_r.cmd_buffer_empty_flag && !st_r.load) begin
					st_nxt.act_cmd  = st_r.cmd;
					st_nxt.act_data = st_r.data;
					st_nxt.cmd_buffer_empty_flag    = 1'b1;
					st_nxt.clean    = 1'b1;
					st_nxt.blank    = 1'b0;
					st_nxt.eng      = E_WAIT;
					st_nxt.row      = 10'h000;
					st_nxt.end_row  = 10'h3ff;
					unique case (st_r.cmd)
						`EE_CMD_PROG: begin
							st_nxt.row     = st_r.addr[10:1];
							st_nxt.end_row = st_r.addr[10:1];
							st_nxt.cnt     = PROG_TICKS;
						end
						`EE_CMD_SERASE: begin
							st_nxt.row     = {st_r.addr[10:2], 1'b0};
							st_nxt.end_row = {st_r.addr[10:2], 1'b1};
							st_nxt.cnt     = SERASE_TICKS;
						end
						`EE_CMD_MERASE: st_nxt.cnt = MERASE_TICKS;
						default:        st_nxt.eng = E_WALK;
					endcase
				end
			end
			E_WAIT: begin
				if (st_r.tick) begin
					if (st_r.cnt <= 16'h0001) begin
						st_nxt.eng = E_WALK;
					end else begin
						st_nxt.cnt = st_r.cnt - 16'h0001;
					end
				end
			end
			E_WALK: begin
				if (st_r.act_cmd == `EE_CMD_VERIFY) begin
					if (mem[st_r.row] != `EE_ERASED) begin
						st_nxt.clean = 1'b0;
					end
				end else begin
					mem_we = 1'b1;
					if (st_r.act_cmd == `EE_CMD_PROG) begin
						mem_wdata = st_r.act_data;
					end
				end
				if (st_r.row == st_r.end_row) begin
					st_nxt.eng = E_IDLE;
					if (st_r.act_cmd == `EE_CMD_VERIFY) begin
						st_nxt.blank = st_r.clean && mem[st_r.row] == `EE_ERASED;
					end
				end else begin
					st_nxt.row = st_r.row + 10'h001;
				end
			end
			default: st_nxt.eng = E_IDLE;
		endcase
		st_nxt.irq = (st_r.cmd_buffer_empty_irq_en && st_r.cmd_buffer_empty_flag) || (st_r.ccie && cmd_complete_flag);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_r          <= '0;
			st_r.load     <= 1'b1;
			st_r.avs_wait <= 1'b1;
			st_r.cmd_buffer_empty_flag    <= 1'b1;
			st_r.seq      <= S_IDLE;
			st_r.eng      <= E_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_avs_readdata    = st_r.rdata;
	assign o_avs_waitrequest = st_r.avs_wait;
	assign o_cmd_irq         = st_r.irq;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	logic rd_start;
	logic cmd_wr;
	assign rd_start = i_avs_read && arr_hit && st_r.avs_wait && !st_r.mis && !st_r.load;
	assign cmd_wr   = i_avs_write && reg_hit && !st_r.avs_wait && i_avs_byteenable[0] &&
		idx == `EE_REG_CMD && st_r.seq == S_DATA && !st_r.load;

	sequence s_one_cycle;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence
	sequence s_two_cycle;
		o_avs_waitrequest ##1 s_one_cycle;
	endsequence

	a_aligned_read_one: assert property (rd_start && !busy && !misaligned |=> s_one_cycle)
		else $error("aligned read not answered in one cycle");
	a_misaligned_read_two: assert property (rd_start && !busy && misaligned |=> s_two_cycle)
		else $error("misaligned read not answered in two cycles");
	a_busy_read_data: assert property (rd_start && busy |=> o_avs_readdata == 32'h0)
		else $error("array read while busy returned array data");
	a_protected_cmd_refused: assert property (cmd_wr && wd[6:0] == `EE_CMD_PROG &&
		row_prot(st_r.prot, st_r.addr[10:1]) |=> ##1 st_r.pviol && st_r.seq == S_IDLE)
		else $error("program to protected row not refused");
	a_closed_mass_refused: assert property (cmd_wr && wd[6:0] == `EE_CMD_MERASE &&
		!st_r.prot[`EE_PR_OPEN] |=> ##1 st_r.pviol && st_r.cmd_buffer_empty_flag)
		else $error("mass erase with array closed not refused");
	a_open_stays_closed: assert property (!st_r.prot[`EE_PR_OPEN] && !st_r.load |=>
		!st_r.prot[`EE_PR_OPEN])
		else $error("global open bit reopened by software");
	a_sector_pair_rows: assert property (mem_we && st_r.act_cmd == `EE_CMD_SERASE |->
		st_r.end_row[0] && mem_row[9:1] == st_r.end_row[9:1])
		else $error("sector erase outside its two-row sector");
	a_erase_writes_ones: assert property (mem_we && st_r.act_cmd != `EE_CMD_PROG |->
		mem_wdata == 16'hffff)
		else $error("erase wrote a zero bit");
	a_wait_holds_ticks: assert property (st_r.eng == E_WAIT && !st_r.tick |=>
		st_r.eng == E_WAIT)
		else $error("algorithm wait ended without a time base tick");
	a_reset_prot_load: assert property (st_r.load |=> st_r.prot == $past(prot_byte))
		else $error("protection not loaded from the protection byte");
	a_buffer_empty_irq: assert property (st_r.cmd_buffer_empty_irq_en && st_r.cmd_buffer_empty_flag |=> o_cmd_irq)
		else $error("buffer empty interrupt not requested");

endmodule : emulated_eeprom_controller

/* File: avalon_master_model.sv */
// avalon-mm bus master model facing the controller's slave port
`timescale 1ns/1ps
module avalon_master_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_waitrequest,
	input  wire logic [31:0] i_readdata,
	output logic      [15:0] o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata,
	output logic      [3:0]  o_byteenable
);
	initial begin
		o_address = 16'h0000;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h00000000;
		o_byteenable = 4'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// n counts rising edges up to the one where waitrequest is sampled low
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q, output int n);
		@(posedge i_clk_sys);
		o_address <= a;
		o_write <= w;
		o_read <= !w;
		o_writedata <= d;
		o_byteenable <= be;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (i_waitrequest !== 1'b0 && n < 2000);
		// accept edge: the answer stands here, and the request is released here
		q = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
		// released lines show the inverse so a stale value cannot pass
		o_writedata <= ~d;
		o_address <= ~a;
	endtask : xfer
endmodule : avalon_master_model

/* File: testbench.sv */
// self-checking testbench of the emulated eeprom controller
`timescale 1ns/1ps
`include "emulated_eeprom_defs.svh"
module testbench;
	import emulated_eeprom_pkg::*;
	localparam logic [4:0] BASE = 5'h01;
	logic        clk_sys;
	logic        sys_rst;
	logic [15:0] address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        cmd_irq;
	logic [31:0] q;
	int          n;
	int          miscompares;
	int          cmp_count;
	always #2.5 clk_sys = ~clk_sys;
	// short tick counts keep the run brief; timing is internal either way
	emulated_eeprom_controller #(.PROG_TICKS(16'h0003), .SERASE_TICKS(16'h0008),
			.MERASE_TICKS(16'h0004), .REG_BLOCK(`EE_REG_BLOCK)) DUT (
		.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_avs_address(address),
		.i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
		.i_avs_byteenable(byteenable), .i_system_nvm_base_map(BASE),
		.o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest), .o_cmd_irq(cmd_irq));
	avalon_master_model bus (
		.i_clk_sys(clk_sys), .i_waitrequest(waitrequest), .i_readdata(readdata),
		.o_address(address), .o_read(read), .o_write(write),
		.o_writedata(writedata), .o_byteenable(byteenable));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] ra(input logic [3:0] i);
		return {`EE_REG_BLOCK, i, 2'b00};
	endfunction : ra
	function automatic logic [15:0] aa(input logic [10:0] b);
		return {BASE, b};
	endfunction : aa
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rchk(input logic [15:0] a, input logic [3:0] be, input logic [31:0] m,
			input logic [31:0] e);
		bus.xfer(1'b0, a, 32'h00000000, be, q, n);
		chk(q & m, e);
	endtask : rchk
	task automatic wreg(input logic [3:0] i, input logic [7:0] d);
		bus.xfer(1'b1, ra(i), {24'h000000, d}, 4'h1, q, n);
	endtask : wreg
	task automatic cmd(input logic [10:0] b, input logic [15:0] d, input logic [6:0] c);
		bus.xfer(1'b1, aa(b), {16'h0000, d}, 4'h3, q, n);
		wreg(`EE_REG_CMD, {1'b0, c});
	endtask : cmd
	task automatic go_idle(input logic wt);
		int k;
		wreg(`EE_REG_STAT, 8'h80);
		k = 0;
		if (wt) begin
			do begin
				bus.xfer(1'b0, ra(`EE_REG_STAT), 32'h00000000, 4'h1, q, n);
				k++;
			end while (q[6] !== 1'b1 && k < 1000);
			chk(q[7:6], 2'b11);
		end
	endtask : go_idle
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		miscompares++;
		summarize();
	end
	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		miscompares = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rchk(ra(`EE_REG_PROT), 4'h1, 32'hff, 32'hff);
		rchk(ra(`EE_REG_STAT), 4'h1, 32'hf0, 32'hc0);
		for (int i = 0; i < 3; i++) begin
			wreg(i == 2 ? `EE_REG_RSVD_C : 4'(i + 1), 8'hff);
			rchk(ra(i == 2 ? `EE_REG_RSVD_C : 4'(i + 1)), 4'h1, 32'hff, 32'h0);
		end
		rchk(16'h0200, 4'h1, 32'hffffffff, 32'h0);
		rchk(aa(11'h000), 4'h1, 32'hffffffff, 32'hff);
		rchk(aa(11'h7fe), 4'hf, 32'hffffffff, 32'hffff);
		chk(n, 2);
		wreg(`EE_REG_CLKDIV, 8'h00);
		rchk(ra(`EE_REG_CLKDIV), 4'h1, 32'hff, 32'h80);
		$display("test registers done");
		// only erased words are programmed
		cmd(11'h010, 16'h1234, `EE_CMD_PROG);
		go_idle(1'b1);
		cmd(11'h012, 16'h0f0f, `EE_CMD_PROG);
		go_idle(1'b1);
		cmd(11'h014, 16'h5555, `EE_CMD_PROG);
		go_idle(1'b1);
		rchk(aa(11'h010), 4'hf, 32'hffffffff, 32'h1234);
		rchk(aa(11'h011), 4'h1, 32'hffffffff, 32'h34);
		chk(n, 2);
		rchk(aa(11'h011), 4'hf, 32'hffffffff, 32'h340f);
		chk(n, 3);
		$display("test program done");
		cmd(11'h012, 16'h0000, `EE_CMD_SERASE);
		go_idle(1'b0);
		rchk(aa(11'h014), 4'hf, 32'hffffffff, 32'h0);
		go_idle(1'b0);
		wreg(`EE_REG_STAT, 8'h30);
		bus.xfer(1'b0, ra(`EE_REG_STAT), 32'h0, 4'h1, q, n);
		repeat (200) @(posedge clk_sys);
		rchk(aa(11'h010), 4'hf, 32'hffffffff, 32'hffff);
		rchk(aa(11'h012), 4'hf, 32'hffffffff, 32'hffff);
		rchk(aa(11'h014), 4'hf, 32'hffffffff, 32'h5555);
		$display("test sector erase done");
		cmd(11'h020, 16'haaaa, `EE_CMD_PROG);
		go_idle(1'b0);
		cmd(11'h022, 16'h5555, `EE_CMD_PROG);
		go_idle(1'b1);
		rchk(aa(11'h020), 4'hf, 32'hffffffff, 32'haaaa);
		rchk(aa(11'h022), 4'hf, 32'hffffffff, 32'h5555);
		cmd(11'h000, 16'h0000, `EE_CMD_MERASE);
		go_idle(1'b1);
		rchk(aa(11'h022), 4'hf, 32'hffffffff, 32'hffff);
		$display("test pipeline and mass erase done");
		wreg(`EE_REG_PROT, 8'h88);
		wreg(`EE_REG_PROT, 8'h80);
		rchk(ra(`EE_REG_PROT), 4'h1, 32'h8f, 32'h80);
		cmd(11'h7c0, 16'h0000, `EE_CMD_PROG);
		rchk(ra(`EE_REG_STAT), 4'h1, 32'h30, 32'h20);
		wreg(`EE_REG_STAT, 8'h30);
		cmd(11'h7be, 16'ha5a5, `EE_CMD_PROG);
		go_idle(1'b1);
		rchk(aa(11'h7be), 4'hf, 32'hffffffff, 32'ha5a5);
		cmd(11'h000, 16'h0000, `EE_CMD_MERASE);
		rchk(ra(`EE_REG_STAT), 4'h1, 32'h30, 32'h20);
		wreg(`EE_REG_STAT, 8'h30);
		wreg(`EE_REG_PROT, 8'h00);
		cmd(11'h100, 16'h0000, `EE_CMD_PROG);
		rchk(ra(`EE_REG_STAT), 4'h1, 32'h30, 32'h20);
		wreg(`EE_REG_STAT, 8'h30);
		$display("test protection done");
		wreg(`EE_REG_CFG, 8'h80);
		repeat (3) @(negedge clk_sys);
		chk(cmd_irq, 1'b1);
		wreg(`EE_REG_CFG, 8'h00);
		repeat (3) @(negedge clk_sys);
		chk(cmd_irq, 1'b0);
		$display("test interrupt done");
		summarize();
	end
endmodule : testbench
